// *** rtl/usc_top.v ***
// Summary of operation
// - Failed baud detection sets bit 14; autobaud request clears it.
// - Bit 15 sets on autobaud enable or abort; clears on resume.
// - Bit 16 busy follows start-bit detection until reception ends.
// - Received byte equal to match value sets bit 17 until cleared.
// - Break request sets bit 18; break stop bit clears it.
// - Bit 19 shows mute; hardware moves it, mute request sets it.
// - Wakeup method select picks the mute entry and exit sequence.
// - Clear bits 0 and 1 clear parity and framing error flags.
// - Clear bit 2 clears noise flag; a zero there changes nothing.
// - Clear bit 3 clears the overrun flag.
// - Clear bit 4 clears the idle line flag.
// - Clear bits 6 and 9 clear transmit complete and CTS change.
// - Clear bits 11 and 17 clear receive timeout and character match.
// - Receive word holds the shifted-in character in bits 8:0.
// - With receive parity on, the top character bit is the parity.
// - Transmit word bits 8:0 are read/write and feed the shifter.
// - With transmit parity on, the top bit is replaced by parity.
// - Autobaud request clears flags and rearms detection.
// - Writing the transmit word clears the buffer-empty flag.
`timescale 1ns/1ps
`include "usc_defines.vh"

module usc_top #(
  parameter AW = 8
) (
  input wire core_clk_in,
  input wire rst_b_in,
  input wire [AW-1:0] s_axi_awaddr_in,
  input wire s_axi_awvalid_in,
  output wire s_axi_awready_out,
  input wire [31:0] s_axi_wdata_in,
  input wire [3:0] s_axi_wstrb_in,
  input wire s_axi_wvalid_in,
  output wire s_axi_wready_out,
  output wire [1:0] s_axi_bresp_out,
  output wire s_axi_bvalid_out,
  input wire s_axi_bready_in,
  input wire [AW-1:0] s_axi_araddr_in,
  input wire s_axi_arvalid_in,
  output wire s_axi_arready_out,
  output wire [31:0] s_axi_rdata_out,
  output wire [1:0] s_axi_rresp_out,
  output wire s_axi_rvalid_out,
  input wire s_axi_rready_in,
  input wire [8:0] rx_shift_word_in,
  input wire rx_load_in,
  input wire rx_start_in,
  input wire rx_end_in,
  input wire parity_err_set_in,
  input wire framing_err_set_in,
  input wire noise_set_in,
  input wire overrun_set_in,
  input wire idle_line_set_in,
  input wire tx_complete_set_in,
  input wire cts_change_set_in,
  input wire cts_level_in,
  input wire rx_timeout_set_in,
  input wire tx_taken_in,
  input wire autobaud_fail_in,
  input wire autobaud_abort_in,
  input wire break_stop_bit_in,
  input wire mute_enter_in,
  input wire wake_idle_in,
  input wire wake_addr_in,
  output reg [8:0] tx_word_out,
  output reg tx_buffer_empty_out,
  output reg autobaud_start_out,
  output reg autobaud_enable_out,
  output reg break_pending_out,
  output reg mute_out,
  output reg rx_parity_en_out,
  output reg word9_out,
  output reg wakeup_method_select_out
);

  ////////////////////////////////////////////////////////////////////////
  // Bus slave

  wire wr_en;
  wire [AW-1:0] wr_addr;
  wire [31:0] wr_data;
  wire [3:0] wr_strb;
  wire rd_en;
  reg [31:0] rd_data;
  reg rd_ok;
  reg wr_ok;

  usc_axil_slave #(
    .AW(AW)
  ) u_slave (
    .core_clk_in(core_clk_in),
    .rst_b_in(rst_b_in),
    .awaddr_in(s_axi_awaddr_in),
    .awvalid_in(s_axi_awvalid_in),
    .awready_out(s_axi_awready_out),
    .wdata_in(s_axi_wdata_in),
    .wstrb_in(s_axi_wstrb_in),
    .wvalid_in(s_axi_wvalid_in),
    .wready_out(s_axi_wready_out),
    .bresp_out(s_axi_bresp_out),
    .bvalid_out(s_axi_bvalid_out),
    .bready_in(s_axi_bready_in),
    .araddr_in(s_axi_araddr_in),
    .arvalid_in(s_axi_arvalid_in),
    .arready_out(s_axi_arready_out),
    .rdata_out(s_axi_rdata_out),
    .rresp_out(s_axi_rresp_out),
    .rvalid_out(s_axi_rvalid_out),
    .rready_in(s_axi_rready_in),
    .wr_en_out(wr_en),
    .wr_addr_out(wr_addr),
    .wr_data_out(wr_data),
    .wr_strb_out(wr_strb),
    .wr_ok_in(wr_ok),
    .rd_en_out(rd_en),
    .rd_data_in(rd_data),
    .rd_ok_in(rd_ok)
  );

  // Byte strobes widened to a bit mask
  function [31:0] lanes;
    input [3:0] s;
    begin
      lanes = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    end
  endfunction

  function hit;
    input [AW-1:0] a;
    input [7:0] off;
    begin
      hit = (a == off[AW-1:0]);
    end
  endfunction

  wire [31:0] wmask = lanes(wr_strb);
  wire [31:0] wbits = wr_data & wmask;
  wire wr_req = wr_en & hit(wr_addr, `USC_OFF_REQ);
  wire wr_clr = wr_en & hit(wr_addr, `USC_OFF_CLR);
  wire wr_txw = wr_en & hit(wr_addr, `USC_OFF_TXW);
  wire wr_ctl = wr_en & hit(wr_addr, `USC_OFF_CTL);
  wire rd_rxw = rd_en & hit(s_axi_araddr_in, `USC_OFF_RXW);

  // Strobes from one-shot registers
  wire [31:0] clr = wr_clr ? wbits : 32'h00000000;
  wire [31:0] req = wr_req ? wbits : 32'h00000000;
  wire abrd_req = req[`USC_REQ_ABRD];
  wire brk_req = req[`USC_REQ_BRK];
  wire mute_req = req[`USC_REQ_MUTE];

  ////////////////////////////////////////////////////////////////////////
  // Control register

  reg [31:0] ctl_q;
  wire [31:0] ctl_d = (ctl_q & ~wmask) | wbits;
  wire [7:0] match_val = ctl_q[`USC_C_MHI:`USC_C_MLO];

  always @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ctl_q <= `USC_CTL_RST;
      autobaud_enable_out <= 1'b0;
      rx_parity_en_out <= 1'b0;
      word9_out <= 1'b0;
      wakeup_method_select_out <= `USC_WAKE_IDLE;
    end else if (wr_ctl) begin
      ctl_q <= ctl_d;
      autobaud_enable_out <= ctl_d[`USC_C_ABEN];
      rx_parity_en_out <= ctl_d[`USC_C_RXPAR];
      word9_out <= ctl_d[`USC_C_W9];
      wakeup_method_select_out <= ctl_d[`USC_C_WAKE];
    end
  end

  wire abr_on = wr_ctl & ctl_d[`USC_C_ABEN] & ~ctl_q[`USC_C_ABEN];

  ////////////////////////////////////////////////////////////////////////
  // Lower status flags, set wins over clear

  reg pe_q, fe_q, ne_q, ovr_q, idle_q, rxne_q, txc_q, cts_q, ctsl_q;
  reg rxto_q;

  always @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pe_q <= 1'b0;
      fe_q <= 1'b0;
      ne_q <= 1'b0;
      ovr_q <= 1'b0;
      idle_q <= 1'b0;
      rxne_q <= 1'b0;
      txc_q <= 1'b1;
      cts_q <= 1'b0;
      ctsl_q <= 1'b0;
      rxto_q <= 1'b0;
    end else begin
      pe_q <= (pe_q & ~clr[`USC_B_PE]) | parity_err_set_in;
      fe_q <= (fe_q & ~clr[`USC_B_FE]) | framing_err_set_in;
      ne_q <= (ne_q & ~clr[`USC_B_NE]) | noise_set_in;
      ovr_q <= (ovr_q & ~clr[`USC_B_OVR]) | overrun_set_in;
      idle_q <= (idle_q & ~clr[`USC_B_IDLE]) | idle_line_set_in;
      rxne_q <= (rxne_q & ~rd_rxw) | rx_load_in;
      txc_q <= (txc_q & ~clr[`USC_B_TXC] & ~wr_txw)
        | tx_complete_set_in;
      cts_q <= (cts_q & ~clr[`USC_B_CTS]) | cts_change_set_in;
      ctsl_q <= cts_level_in;
      rxto_q <= (rxto_q & ~clr[`USC_B_RXTO]) | rx_timeout_set_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Upper status flags

  reg abre_q, abr_q, bsy_q, cm_q;
  wire cm_hit = rx_load_in & (rx_shift_word_in[7:0] == match_val);

  always @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      abre_q <= 1'b0;
      abr_q <= 1'b0;
      bsy_q <= 1'b0;
      cm_q <= 1'b0;
      autobaud_start_out <= 1'b0;
    end else begin
      abre_q <= (abre_q & ~abrd_req) | autobaud_fail_in;
      abr_q <= (abr_q & ~abrd_req)
        | abr_on | autobaud_abort_in;
      autobaud_start_out <= abrd_req;
      if (rx_start_in) begin
        bsy_q <= 1'b1;
      end else if (rx_end_in) begin
        bsy_q <= 1'b0;
      end
      cm_q <= (cm_q & ~clr[`USC_B_CM]) | cm_hit;
    end
  end

  // Break stays pending until its stop bit goes out
  always @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      break_pending_out <= 1'b0;
    end else if (brk_req) begin
      break_pending_out <= 1'b1;
    end else if (break_stop_bit_in) begin
      break_pending_out <= 1'b0;
    end
  end

  // Mute sequence depends on wakeup method
  always @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      mute_out <= 1'b0;
    end else if (mute_req) begin
      mute_out <= 1'b1;
    end else begin
      case (wakeup_method_select_out)
        `USC_WAKE_IDLE: begin
          if (wake_idle_in) begin
            mute_out <= 1'b0;
          end
        end
        `USC_WAKE_ADDR: begin
          if (wake_addr_in) begin
            mute_out <= 1'b0;
          end else if (mute_enter_in) begin
            mute_out <= 1'b1;
          end
        end
        default: begin
          mute_out <= mute_out;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Data registers

  reg [8:0] rxw_q;
  reg [8:0] txw_q;
  wire [8:0] tx_fmt;

  // Parity arrives as the top bit of the shifted character
  always @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rxw_q <= 9'h000;
    end else if (rx_load_in) begin
      rxw_q <= word9_out ? rx_shift_word_in
        : {1'b0, rx_shift_word_in[7:0]};
    end
  end

  usc_tx_format u_fmt (
    .data_in(wr_data[8:0]),
    .parity_en_in(ctl_q[`USC_C_TXPAR]),
    .odd_in(ctl_q[`USC_C_ODD]),
    .word9_in(ctl_q[`USC_C_W9]),
    .word_out(tx_fmt)
  );

  // A new write wins over the shifter taking the old word
  always @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      txw_q <= 9'h000;
      tx_word_out <= 9'h000;
      tx_buffer_empty_out <= 1'b1;
    end else begin
      if (wr_txw) begin
        txw_q <= (txw_q & ~wmask[8:0]) | wbits[8:0];
        tx_word_out <= tx_fmt;
        tx_buffer_empty_out <= 1'b0;
      end else if (tx_taken_in) begin
        tx_buffer_empty_out <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read decode

  wire [31:0] sts = {12'h000,
    mute_out, break_pending_out, cm_q, bsy_q, abr_q, abre_q,
    2'b00, rxto_q, ctsl_q, cts_q, 1'b0, tx_buffer_empty_out,
    txc_q, rxne_q, idle_q, ovr_q, ne_q, fe_q, pe_q};

  always @* begin
    rd_data = 32'h00000000;
    rd_ok = 1'b1;
    case (s_axi_araddr_in)
      `USC_OFF_REQ: rd_data = 32'h00000000;
      `USC_OFF_STS: rd_data = sts;
      `USC_OFF_CLR: rd_data = 32'h00000000;
      `USC_OFF_RXW: rd_data = {23'h000000, rxw_q};
      `USC_OFF_TXW: rd_data = {23'h000000, txw_q};
      `USC_OFF_CTL: rd_data = ctl_q;
      default: rd_ok = 1'b0;
    endcase
  end

  // Status is accepted but ignored
  always @* begin
    case (wr_addr)
      `USC_OFF_REQ: wr_ok = 1'b1;
      `USC_OFF_STS: wr_ok = 1'b1;
      `USC_OFF_CLR: wr_ok = 1'b1;
      `USC_OFF_RXW: wr_ok = 1'b1;
      `USC_OFF_TXW: wr_ok = 1'b1;
      `USC_OFF_CTL: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

endmodule // usc_top

// *** rtl/usc_defines.vh ***
`ifndef USC_DEFINES_VH
`define USC_DEFINES_VH

// Register byte offsets
`define USC_OFF_REQ 8'h18
`define USC_OFF_STS 8'h1C
`define USC_OFF_CLR 8'h20
`define USC_OFF_RXW 8'h24
`define USC_OFF_TXW 8'h28
`define USC_OFF_CTL 8'h2C

// Request register bits
`define USC_REQ_ABRD 0
`define USC_REQ_BRK 1
`define USC_REQ_MUTE 2

// Status and flag-clear bit positions
`define USC_B_PE 0
`define USC_B_FE 1
`define USC_B_NE 2
`define USC_B_OVR 3
`define USC_B_IDLE 4
`define USC_B_RXNE 5
`define USC_B_TXC 6
`define USC_B_TXBE 7
`define USC_B_CTS 9
`define USC_B_CTSL 10
`define USC_B_RXTO 11
`define USC_B_ABRE 14
`define USC_B_ABR 15
`define USC_B_BSY 16
`define USC_B_CM 17
`define USC_B_BRK 18
`define USC_B_MUTE 19

// Control register bits
`define USC_C_RXPAR 0
`define USC_C_TXPAR 1
`define USC_C_ODD 2
`define USC_C_W9 3
`define USC_C_WAKE 4
`define USC_C_ABEN 5
`define USC_C_MLO 8
`define USC_C_MHI 15
`define USC_CTL_RST 32'h00000000

// Wakeup method encodings
`define USC_WAKE_IDLE 1'b0
`define USC_WAKE_ADDR 1'b1

// AXI responses
`define USC_RESP_OK 2'h0
`define USC_RESP_ERR 2'h2

`endif

// *** rtl/usc_tx_format.v ***
`timescale 1ns/1ps
`include "usc_defines.vh"

module usc_tx_format (
  input wire [8:0] data_in,
  input wire parity_en_in,
  input wire odd_in,
  input wire word9_in,
  output reg [8:0] word_out
);

  function par;
    input [7:0] d;
    input odd;
    begin
      par = (^d) ^ odd;
    end
  endfunction

  // Top bit of the character replaced by computed parity
  always @* begin
    word_out = word9_in ? data_in : {1'b0, data_in[7:0]};
    if (parity_en_in) begin
      if (word9_in) begin
        word_out[8] = par(data_in[7:0], odd_in);
      end else begin
        word_out[7] = par({1'b0, data_in[6:0]}, odd_in);
      end
    end
  end

endmodule // usc_tx_format

// *** rtl/usc_axil_slave.v ***
`timescale 1ns/1ps
`include "usc_defines.vh"

module usc_axil_slave #(
  parameter AW = 8
) (
  input wire core_clk_in,
  input wire rst_b_in,
  input wire [AW-1:0] awaddr_in,
  input wire awvalid_in,
  output reg awready_out,
  input wire [31:0] wdata_in,
  input wire [3:0] wstrb_in,
  input wire wvalid_in,
  output reg wready_out,
  output reg [1:0] bresp_out,
  output reg bvalid_out,
  input wire bready_in,
  input wire [AW-1:0] araddr_in,
  input wire arvalid_in,
  output reg arready_out,
  output reg [31:0] rdata_out,
  output reg [1:0] rresp_out,
  output reg rvalid_out,
  input wire rready_in,
  output wire wr_en_out,
  output reg [AW-1:0] wr_addr_out,
  output reg [31:0] wr_data_out,
  output reg [3:0] wr_strb_out,
  input wire wr_ok_in,
  output wire rd_en_out,
  input wire [31:0] rd_data_in,
  input wire rd_ok_in
);

  reg aw_full_q;
  reg w_full_q;

  assign wr_en_out = aw_full_q & w_full_q & ~bvalid_out;
  assign rd_en_out = arvalid_in & arready_out;

  always @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      awready_out <= 1'b1;
      wready_out <= 1'b1;
      bvalid_out <= 1'b0;
      bresp_out <= `USC_RESP_OK;
      wr_addr_out <= {AW{1'b0}};
      wr_data_out <= 32'h00000000;
      wr_strb_out <= 4'h0;
      arready_out <= 1'b1;
      rvalid_out <= 1'b0;
      rresp_out <= `USC_RESP_OK;
      rdata_out <= 32'h00000000;
    end else begin
      if (awvalid_in && awready_out) begin
        aw_full_q <= 1'b1;
        awready_out <= 1'b0;
        wr_addr_out <= awaddr_in;
      end
      if (wvalid_in && wready_out) begin
        w_full_q <= 1'b1;
        wready_out <= 1'b0;
        wr_data_out <= wdata_in;
        wr_strb_out <= wstrb_in;
      end
      if (wr_en_out) begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        bvalid_out <= 1'b1;
        bresp_out <= wr_ok_in ? `USC_RESP_OK : `USC_RESP_ERR;
      end
      if (bvalid_out && bready_in) begin
        bvalid_out <= 1'b0;
        awready_out <= 1'b1;
        wready_out <= 1'b1;
      end
      if (rd_en_out) begin
        arready_out <= 1'b0;
        rvalid_out <= 1'b1;
        rdata_out <= rd_data_in;
        rresp_out <= rd_ok_in ? `USC_RESP_OK : `USC_RESP_ERR;
      end
      if (rvalid_out && rready_in) begin
        rvalid_out <= 1'b0;
        arready_out <= 1'b1;
      end
    end
  end

endmodule // usc_axil_slave

// *** tb/usc_props.sv ***
`timescale 1ns/1ps
module usc_props (
  input wire core_clk_in,
  input wire rst_b_in,
  input wire s_axi_awvalid_in,
  input wire s_axi_awready_out,
  input wire s_axi_wvalid_in,
  input wire s_axi_wready_out,
  input wire s_axi_bvalid_out,
  input wire tx_taken_in,
  input wire break_stop_bit_in,
  input wire mute_enter_in,
  input wire wake_idle_in,
  input wire wake_addr_in,
  input wire tx_buffer_empty_out,
  input wire break_pending_out,
  input wire mute_out,
  input wire wakeup_method_select_out,
  input wire [8:0] tx_word_out,
  input wire autobaud_start_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_b_in);
  ////////////////////////////////////////
  sequence s_wboth;
    s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in
      && s_axi_wready_out;
  endsequence
  sequence s_wdone;
    $rose(s_axi_bvalid_out);
  endsequence
  ////////////////////////////////////////
  chk_write_lat: assert property (s_wboth |-> ##2 s_axi_bvalid_out)
    else $error("write response not two cycles after handshake");
  chk_break_set: assert property ($rose(break_pending_out)
    |-> s_wdone)
    else $error("break pending rose without a register write");
  chk_break_clr: assert property (break_stop_bit_in |=>
    !break_pending_out || $rose(s_axi_bvalid_out))
    else $error("break pending not cleared by stop bit");
  chk_mute_idle: assert property (!wakeup_method_select_out
    && wake_idle_in |=> !mute_out || $rose(s_axi_bvalid_out))
    else $error("idle wakeup did not leave mute");
  chk_mute_addr: assert property (wakeup_method_select_out
    && mute_enter_in && !wake_addr_in |=> mute_out)
    else $error("address method did not enter mute");
  chk_txbe_fell: assert property ($fell(tx_buffer_empty_out)
    |-> s_wdone)
    else $error("buffer empty fell without a write");
  chk_txbe_take: assert property (tx_taken_in |=>
    tx_buffer_empty_out || $rose(s_axi_bvalid_out))
    else $error("buffer empty not set after take");
  chk_txword_load: assert property ($changed(tx_word_out)
    |-> s_wdone)
    else $error("transmit word changed without a write");
  chk_ab_pulse: assert property (autobaud_start_out |=>
    !autobaud_start_out)
    else $error("autobaud start longer than one cycle");
endmodule // usc_props

bind usc_top usc_props usc_props_inst (
  .core_clk_in, .rst_b_in, .s_axi_awvalid_in, .s_axi_awready_out,
  .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bvalid_out, .tx_taken_in,
  .break_stop_bit_in, .mute_enter_in, .wake_idle_in, .wake_addr_in,
  .tx_buffer_empty_out, .break_pending_out, .mute_out,
  .wakeup_method_select_out, .tx_word_out, .autobaud_start_out
);

// *** tb/usc_line_model.sv ***
`timescale 1ns/1ps
module usc_line_model (
  input wire core_clk_in,
  input wire rx_go_in,
  input wire [8:0] rx_char_in,
  input wire slow_in,
  input wire tx_buffer_empty_in,
  input wire break_pending_in,
  output logic [8:0] rx_shift_word_out = 0,
  output logic rx_load_out = 0,
  output logic rx_start_out = 0,
  output logic rx_end_out = 0,
  output logic tx_taken_out = 0,
  output logic break_stop_bit_out = 0
);
  // Frame: start bit, character time, hand-over, end
  initial begin
    forever begin
      @(posedge core_clk_in);
      if (rx_go_in) begin
        rx_start_out <= 1;
        @(posedge core_clk_in) rx_start_out <= 0;
        repeat (slow_in ? 12 : 2) @(posedge core_clk_in);
        rx_shift_word_out <= rx_char_in;
        rx_load_out <= 1;
        @(posedge core_clk_in) rx_load_out <= 0;
        // Shift word no longer valid
        rx_shift_word_out <= ~rx_char_in;
        rx_end_out <= 1;
        @(posedge core_clk_in) rx_end_out <= 0;
      end
    end
  end
  ////////////////////////////////////////
  initial begin
    forever begin
      @(posedge core_clk_in);
      if (tx_buffer_empty_in === 1'b0) begin
        repeat (slow_in ? 9 : 1) @(posedge core_clk_in);
        tx_taken_out <= 1;
        @(posedge core_clk_in) tx_taken_out <= 0;
      end
    end
  end
  initial begin
    forever begin
      @(posedge core_clk_in);
      if (break_pending_in === 1'b1) begin
        repeat (slow_in ? 20 : 4) @(posedge core_clk_in);
        break_stop_bit_out <= 1;
        @(posedge core_clk_in) break_stop_bit_out <= 0;
      end
    end
  end
endmodule // usc_line_model

// *** tb/test_usart_status_clear_data_regs.sv ***
`timescale 1ns/1ps
`include "usc_defines.vh"
module test_usart_status_clear_data_regs;
  localparam [7:0] RQ = `USC_OFF_REQ, ST = `USC_OFF_STS, CL = `USC_OFF_CLR;
  localparam [7:0] RX = `USC_OFF_RXW, TX = `USC_OFF_TXW, CT = `USC_OFF_CTL;
  localparam [31:0] FM = 32'h00000A5F;
  logic core_clk_in = 0, rst_b_in = 0, s_axi_awvalid_in = 0, rx_go = 0;
  logic s_axi_wvalid_in = 0, s_axi_bready_in = 0, s_axi_arvalid_in = 0;
  logic s_axi_rready_in = 0, slow = 1;
  logic [7:0] s_axi_awaddr_in = 0, s_axi_araddr_in = 0;
  logic [31:0] s_axi_wdata_in = 0, d, r, e;
  logic [3:0] s_axi_wstrb_in = 4'hF, c;
  logic [12:0] ls = 0;
  logic [8:0] rx_char = 0, m;
  wire s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, rx_end_in;
  wire s_axi_arready_out, s_axi_rvalid_out, rx_load_in, rx_start_in;
  wire tx_taken_in, break_stop_bit_in, tx_buffer_empty_out, mute_out;
  wire autobaud_start_out, autobaud_enable_out, break_pending_out;
  wire rx_parity_en_out, word9_out, wakeup_method_select_out;
  wire [1:0] s_axi_bresp_out, s_axi_rresp_out;
  wire [31:0] s_axi_rdata_out;
  wire [8:0] rx_shift_word_in, tx_word_out;
  int n_mismatch = 0, total_checks = 0, seed = 32'hEBBA, ab_cnt = 0;

  usc_top usc_top_inst (
    .core_clk_in, .rst_b_in, .s_axi_awaddr_in, .s_axi_awvalid_in,
    .s_axi_awready_out, .s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_wvalid_in,
    .s_axi_wready_out, .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in,
    .s_axi_araddr_in, .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out,
    .s_axi_rresp_out, .s_axi_rvalid_out, .s_axi_rready_in, .rx_shift_word_in,
    .rx_load_in, .rx_start_in, .rx_end_in, .parity_err_set_in(ls[0]),
    .framing_err_set_in(ls[1]), .noise_set_in(ls[2]),
    .overrun_set_in(ls[3]), .idle_line_set_in(ls[4]),
    .tx_complete_set_in(ls[5]), .cts_change_set_in(ls[6]),
    .cts_level_in(1'b0), .rx_timeout_set_in(ls[7]), .tx_taken_in,
    .autobaud_fail_in(ls[8]), .autobaud_abort_in(ls[9]), .break_stop_bit_in,
    .mute_enter_in(ls[10]), .wake_idle_in(ls[11]), .wake_addr_in(ls[12]),
    .tx_word_out, .tx_buffer_empty_out, .autobaud_start_out,
    .autobaud_enable_out, .break_pending_out, .mute_out, .rx_parity_en_out,
    .word9_out, .wakeup_method_select_out
  );
  usc_line_model usc_line_model_inst (
    .core_clk_in, .rx_go_in(rx_go), .rx_char_in(rx_char), .slow_in(slow),
    .tx_buffer_empty_in(tx_buffer_empty_out),
    .break_pending_in(break_pending_out),
    .rx_shift_word_out(rx_shift_word_in), .rx_load_out(rx_load_in),
    .rx_start_out(rx_start_in), .rx_end_out(rx_end_in),
    .tx_taken_out(tx_taken_in), .break_stop_bit_out(break_stop_bit_in)
  );
  always #10 core_clk_in = ~core_clk_in;
  always @(posedge core_clk_in)
    if (autobaud_start_out === 1'b1) ab_cnt <= ab_cnt + 1;
  ////////////////////////////////////////
  task tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task guard(inout int n);
    n++;
    if (n > 300) begin
      chk(32'h0, 32'h1);
      tally_and_finish;
    end
  endtask
  task wr(input [7:0] a, input [31:0] v, input [1:0] er = `USC_RESP_OK);
    int n;
    logic ap, wp, ah, wh, bh;
    logic [1:0] rs;
    @(posedge core_clk_in);
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= v;
    s_axi_awvalid_in <= 1;
    s_axi_wvalid_in <= 1;
    s_axi_bready_in <= 1;
    {n, ap, wp, bh} = {32'd0, 3'b110};
    while (!bh) begin
      @(negedge core_clk_in);
      {ah, wh, bh} = {s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out};
      rs = s_axi_bresp_out;
      @(posedge core_clk_in);
      if (ah && ap) {s_axi_awvalid_in, ap} <= 2'b00;
      if (wh && wp) {s_axi_wvalid_in, wp} <= 2'b00;
      guard(n);
    end
    s_axi_bready_in <= 0;
    chk({30'h0, rs}, {30'h0, er});
  endtask
  task rd(input [7:0] a, output [31:0] v, input [1:0] er = `USC_RESP_OK);
    int n;
    logic ap, ah, rh;
    logic [1:0] rs;
    @(posedge core_clk_in);
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1;
    s_axi_rready_in <= 1;
    {n, ap, rh} = {32'd0, 2'b10};
    while (!rh) begin
      @(negedge core_clk_in);
      {ah, rh, rs} = {s_axi_arready_out, s_axi_rvalid_out, s_axi_rresp_out};
      v = s_axi_rdata_out;
      @(posedge core_clk_in);
      if (ah && ap) {s_axi_arvalid_in, ap} <= 2'b00;
      guard(n);
    end
    s_axi_rready_in <= 0;
    chk({30'h0, rs}, {30'h0, er});
  endtask
  task rc(input [7:0] a, input [31:0] m, input [31:0] e);
    rd(a, r);
    chk(r & m, e);
  endtask
  task pw(input [31:0] m, input [31:0] e);
    int n;
    n = 0;
    rd(ST, r);
    while ((r & m) !== e) begin
      guard(n);
      rd(ST, r);
    end
  endtask
  task pulse(input [12:0] v);
    @(posedge core_clk_in) ls <= v;
    @(posedge core_clk_in) ls <= 0;
    @(posedge core_clk_in);
  endtask
  function [8:0] exp_tx(input [8:0] v, input [3:0] k);
    if (!k[1]) exp_tx = v;
    else if (k[3]) exp_tx = {^v[7:0] ^ k[2], v[7:0]};
    else exp_tx = {1'b0, ^v[6:0] ^ k[2], v[6:0]};
  endfunction
  // Byte strobes as a bit mask
  function [31:0] lm(input [3:0] s);
    lm = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction
  ////////////////////////////////////////
  initial begin
    repeat (3) @(posedge core_clk_in);
    rst_b_in <= 1;
    rc(ST, 32'hFFFFFFFF, 32'h000000C0);
    wr(ST, 32'hFFFFFFFF);
    rc(ST, 32'hFFFFFFFF, 32'h000000C0);
    rc(CL, 32'hFFFFFFFF, 32'h0);
    wr(8'h40, 32'h1, `USC_RESP_ERR);
    rd(8'h40, r, `USC_RESP_ERR);
    repeat (6) begin
      pulse(13'h00FF);
      rc(ST, FM, FM);
      d = $random(seed);
      c = $random(seed);
      s_axi_wstrb_in <= c;
      wr(CL, d);
      e = (FM & ~(d & lm(c))) | 32'h80;
      rc(ST, FM | 32'h80, e);
    end
    s_axi_wstrb_in <= 4'hF;
    pulse(13'h0100);
    rc(ST, 32'hC000, 32'h4000);
    wr(CT, 32'h20);
    chk(autobaud_enable_out, 1);
    rc(ST, 32'hC000, 32'hC000);
    wr(RQ, 32'h1);
    rc(ST, 32'hC000, 32'h0);
    chk(ab_cnt, 1);
    pulse(13'h0200);
    rc(ST, 32'hC000, 32'h8000);
    wr(RQ, 32'h1);
    rc(ST, 32'hC000, 32'h0);
    wr(RQ, 32'h2);
    rc(ST, 32'h40000, 32'h40000);
    pw(32'h40000, 32'h0);
    wr(CT, 32'h0);
    wr(RQ, 32'h4);
    pulse(13'h1000);
    rc(ST, 32'h80000, 32'h80000);
    pulse(13'h0800);
    chk(mute_out, 0);
    wr(CT, 32'h10);
    chk(wakeup_method_select_out, 1);
    pulse(13'h0400);
    rc(ST, 32'h80000, 32'h80000);
    pulse(13'h1000);
    chk(mute_out, 0);
    for (int i = 0; i < 5; i++) begin
      c = $random(seed);
      d = (i == 1) ? 32'h15A : $random(seed);
      wr(CT, {16'h0, 8'h5A, 4'h0, c});
      chk({rx_parity_en_out, word9_out}, {c[0], c[3]});
      wr(CL, 32'h20000);
      @(posedge core_clk_in) {rx_char, rx_go} <= {d[8:0], 1'b1};
      @(posedge core_clk_in) rx_go <= 0;
      pw(32'h10000, 32'h10000);
      pw(32'h10000, 32'h0);
      rc(ST, 32'h20000, {14'h0, d[7:0] == 8'h5A, 17'h0});
      rc(RX, 32'hFFFFFFFF, d & (c[3] ? 32'h1FF : 32'hFF));
    end
    for (int i = 0; i < 6; i++) begin
      c = $random(seed);
      d = $random(seed);
      wr(CT, {28'h0, c});
      wr(TX, d);
      m = c[3] ? 9'h1FF : 9'h0FF;
      chk(tx_word_out & m, exp_tx(d[8:0], c) & m);
      chk(tx_buffer_empty_out, 0);
      rc(ST, 32'h40, 32'h0);
      rc(TX, 32'h1FF, d & 32'h1FF);
      pw(32'h80, 32'h80);
    end
    @(posedge core_clk_in) rst_b_in <= 0;
    repeat (3) @(posedge core_clk_in);
    rst_b_in <= 1;
    rc(ST, 32'hFFFFFFFF, 32'h000000C0);
    chk(tx_word_out, 0);
    tally_and_finish;
  end
endmodule // test_usart_status_clear_data_regs
